// File: hw/sbo_ctrl.sv
// Functional notes
// - one signed eight-bit offset register per axis, range -128 to 127
// - offset shifts the axis output by two output steps per code
// - x, y, z offsets at consecutive addresses, each shifts only its axis
// - order bit zero: oldest sample read first; zero after reset
// - order bit one: newest sample read first
// - mode bits refused while active or second pin trigger function set
// - stream mode overwrites the oldest sample when full, keeps latest 32
// - stop mode discards new samples when full
// - trigger mode before trigger: circular, at most mark count samples kept
// - after trigger accept 32 minus mark samples, set overflow, stop
// - overflow cleared and trigger re-armed on flush or full read out
// - trigger only from enabled sources: within, outside, orientation
// - gate clear: flush on every automatic wake/sleep transition
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module sbo_ctrl #(
    parameter int DEPTH = 32,
    parameter int AW = 5,
    parameter int DW = 12
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // raw samples
    input wire logic sample_valid_i,
    input wire logic [DW-1:0] sample_x_i,
    input wire logic [DW-1:0] sample_y_i,
    input wire logic [DW-1:0] sample_z_i,
    // detector events and power transitions
    input wire logic within_threshold_evt_i,
    input wire logic outside_threshold_evt_i,
    input wire logic orientation_evt_i,
    input wire logic wake_sleep_change_i,
    // status
    output logic irq_o,
    output logic store_overflow_flag_o,
    output logic sensor_active_o,
    output logic second_pin_trigger_function_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] offset_r [3];
    logic [7:0] setup_r;
    logic [5:0] fill_level_mark_r;
    logic sensor_active_r, second_pin_trigger_function_r, gate_r, ovf_r;
    logic [sbo_pkg::EVT_BITS-1:0] evt_status_r, evt_mask_r;
    logic [AW-1:0] wr_ptr_r, rd_ptr_r;
    logic [AW:0] count_r, post_cnt_r;
    sbo_pkg::sbo_trig_t trig_r, trig_nxt;
    ////////////////////////////////////////////////////////////////////////////////
    // bus decode
    logic req, wr_req, rd_req, pop_req, hold_ack, take, pop;
    logic setup_wr, mode_locked, flush_wr, flush, activate, lifo;
    logic [5:0] idx;
    logic [7:0] wbyte, setup_nxt;
    sbo_pkg::sbo_mode_t mode, mode_nxt;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign idx = wb_adr_i[7:2];
    assign wbyte = wb_dat_i[7:0];
    assign wr_req = req && wb_we_i && wb_sel_i[0];
    assign rd_req = req && !wb_we_i;
    assign pop_req = rd_req && (idx == sbo_pkg::IDX_DATA_Z);
    assign hold_ack = pop_req && sample_valid_i;
    assign take = req && !hold_ack;
    assign pop = take && pop_req && (count_r != '0);
    assign mode = sbo_pkg::sbo_mode_t'(setup_r[sbo_pkg::SETUP_MODE_LO +: 2]);
    assign lifo = setup_r[sbo_pkg::SETUP_ORDER_BIT];
    assign mode_locked = sensor_active_r || second_pin_trigger_function_r;
    assign setup_wr = take && wr_req && (idx == sbo_pkg::IDX_SETUP);
    always_comb begin
        setup_nxt = wbyte;
        if (mode_locked) begin
            setup_nxt = (wbyte & ~sbo_pkg::SETUP_MODE_MASK) |
                        (setup_r & sbo_pkg::SETUP_MODE_MASK);
        end
    end
    assign mode_nxt = sbo_pkg::sbo_mode_t'(setup_nxt[sbo_pkg::SETUP_MODE_LO +: 2]);
    assign flush_wr = take && wr_req && (idx == sbo_pkg::IDX_SETUP_TWO) &&
                      wbyte[sbo_pkg::TWO_FLUSH_BIT];
    assign activate = take && wr_req && (idx == sbo_pkg::IDX_SENSOR) &&
                      wbyte[sbo_pkg::SENSOR_ACTIVE_BIT] && !sensor_active_r;
    assign flush = flush_wr || activate ||
                   (setup_wr && mode_nxt == sbo_pkg::SBO_MODE_OFF) ||
                   (wake_sleep_change_i && !setup_r[sbo_pkg::SETUP_GATE_BIT]);
    ////////////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 3; i++) begin
                offset_r[i] <= sbo_pkg::RST_BYTE;
            end
        end else if (take && wr_req) begin
            if (idx == sbo_pkg::IDX_X_OFFSET) begin
                offset_r[0] <= wbyte;
            end else if (idx == sbo_pkg::IDX_Y_OFFSET) begin
                offset_r[1] <= wbyte;
            end else if (idx == sbo_pkg::IDX_Z_OFFSET) begin
                offset_r[2] <= wbyte;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            setup_r <= sbo_pkg::RST_BYTE;
        end else if (setup_wr) begin
            setup_r <= setup_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fill_level_mark_r <= '0;
            sensor_active_r <= 1'b0;
            second_pin_trigger_function_r <= 1'b0;
            evt_mask_r <= sbo_pkg::RST_EVT;
        end else if (take && wr_req) begin
            if (idx == sbo_pkg::IDX_SETUP_TWO) begin
                fill_level_mark_r <= wbyte[5:0];
            end else if (idx == sbo_pkg::IDX_SENSOR) begin
                sensor_active_r <= wbyte[sbo_pkg::SENSOR_ACTIVE_BIT];
                second_pin_trigger_function_r <= wbyte[sbo_pkg::SENSOR_PIN2_BIT];
            end else if (idx == sbo_pkg::IDX_EVT_MASK) begin
                evt_mask_r <= wbyte[sbo_pkg::EVT_BITS-1:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // offset correction per axis
    logic [DW-1:0] raw [3], corr [3];
    assign raw[0] = sample_x_i;
    assign raw[1] = sample_y_i;
    assign raw[2] = sample_z_i;

    for (genvar a = 0; a < 3; a++) begin : g_axis
        sbo_offset_sat #(
            .DW(DW)
        ) u_sat (
            .raw_i(raw[a]),
            .offset_i(offset_r[a]),
            .corr_o(corr[a])
        );
    end
    ////////////////////////////////////////////////////////////////////////////////
    // sample storage decisions
    logic full, trig_evt, wr_en, drop_old, ovf_set, gate_err, post_inc;
    logic [AW:0] mark_eff, post_limit, count_nxt;
    logic [AW-1:0] rd_addr;
    logic [3*DW-1:0] rd_data;
    assign full = (count_r == (AW+1)'(DEPTH));
    assign mark_eff = (fill_level_mark_r > 6'(DEPTH)) ? (AW+1)'(DEPTH) : fill_level_mark_r[AW:0];
    assign post_limit = (AW+1)'(DEPTH) - mark_eff;
    assign trig_evt = (within_threshold_evt_i && setup_r[sbo_pkg::SETUP_WT_BIT]) ||
                      (outside_threshold_evt_i && setup_r[sbo_pkg::SETUP_OT_BIT]) ||
                      (orientation_evt_i && setup_r[sbo_pkg::SETUP_OR_BIT]);

    always_comb begin
        wr_en = 1'b0;
        drop_old = 1'b0;
        ovf_set = 1'b0;
        gate_err = 1'b0;
        post_inc = 1'b0;
        trig_nxt = trig_r;
        if (!flush && sample_valid_i && mode != sbo_pkg::SBO_MODE_OFF) begin
            if (gate_r) begin
                gate_err = 1'b1;
            end else begin
                case (mode)
                    sbo_pkg::SBO_MODE_STREAM: begin
                        wr_en = 1'b1;
                        drop_old = full;
                        ovf_set = full;
                    end
                    sbo_pkg::SBO_MODE_STOP: begin
                        wr_en = !full;
                        ovf_set = full;
                    end
                    default: begin
                        case (trig_r)
                            sbo_pkg::SBO_TRIG_ARMED: begin
                                wr_en = (mark_eff != '0);
                                drop_old = (mark_eff != '0) && (count_r >= mark_eff);
                            end
                            sbo_pkg::SBO_TRIG_COLLECT: begin
                                wr_en = 1'b1;
                                post_inc = 1'b1;
                                if (post_cnt_r + 1'b1 >= post_limit) begin
                                    ovf_set = 1'b1;
                                    trig_nxt = sbo_pkg::SBO_TRIG_HALTED;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                endcase
            end
        end
        if (mode == sbo_pkg::SBO_MODE_TRIGGER && trig_r == sbo_pkg::SBO_TRIG_ARMED &&
            trig_evt && !flush) begin
            trig_nxt = (post_limit == '0) ? sbo_pkg::SBO_TRIG_HALTED : sbo_pkg::SBO_TRIG_COLLECT;
            ovf_set = ovf_set || (post_limit == '0);
        end
        if (flush || (pop && count_r == (AW+1)'(1))) begin
            trig_nxt = sbo_pkg::SBO_TRIG_ARMED;
        end
    end

    assign count_nxt = count_r + (AW+1)'(wr_en) - (AW+1)'(drop_old) - (AW+1)'(pop);
    assign rd_addr = lifo ? (wr_ptr_r - 1'b1) : rd_ptr_r;

    sbo_sample_mem #(
        .WIDTH(3*DW),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_mem (
        .clk_i(clk_i),
        .we_i(wr_en),
        .waddr_i(wr_ptr_r),
        .wdata_i({corr[2], corr[1], corr[0]}),
        .raddr_i(rd_addr),
        .rdata_o(rd_data)
    );
    ////////////////////////////////////////////////////////////////////////////////
    // pointers and fill level
    always_ff @(posedge clk_i) begin
        if (rst_i || flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
            if (pop && lifo) begin
                wr_ptr_r <= wr_ptr_r - 1'b1;
            end else if (wr_en) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (drop_old || (pop && !lifo)) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_r <= sbo_pkg::SBO_TRIG_ARMED;
        end else if (mode != sbo_pkg::SBO_MODE_TRIGGER) begin
            trig_r <= sbo_pkg::SBO_TRIG_ARMED;
        end else begin
            trig_r <= trig_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || trig_nxt == sbo_pkg::SBO_TRIG_ARMED) begin
            post_cnt_r <= '0;
        end else if (post_inc) begin
            post_cnt_r <= post_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || flush || (pop && count_r == (AW+1)'(1))) begin
            ovf_r <= 1'b0;
        end else if (ovf_set) begin
            ovf_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || flush || (pop && count_r == (AW+1)'(1))) begin
            gate_r <= 1'b0;
        end else if (wake_sleep_change_i && setup_r[sbo_pkg::SETUP_GATE_BIT] &&
                     count_r != '0) begin
            gate_r <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // events and interrupt
    logic [sbo_pkg::EVT_BITS-1:0] evt_set, evt_clr;
    always_comb begin
        evt_set = '0;
        evt_set[sbo_pkg::EVT_OVERFLOW] = ovf_set;
        evt_set[sbo_pkg::EVT_MARK] = wr_en && !drop_old && mark_eff != '0 &&
                                     (count_r + 1'b1 == mark_eff);
        evt_set[sbo_pkg::EVT_TRIGGER] = (trig_r == sbo_pkg::SBO_TRIG_ARMED) &&
                                        (trig_nxt != sbo_pkg::SBO_TRIG_ARMED);
        evt_set[sbo_pkg::EVT_GATE_ERR] = gate_err;
    end

    assign evt_clr = (take && wr_req && idx == sbo_pkg::IDX_EVT_STATUS) ?
                     wbyte[sbo_pkg::EVT_BITS-1:0] : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_status_r <= sbo_pkg::RST_EVT;
        end else begin
            evt_status_r <= (evt_status_r & ~evt_clr) | evt_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
            store_overflow_flag_o <= 1'b0;
            sensor_active_o <= 1'b0;
            second_pin_trigger_function_o <= 1'b0;
        end else begin
            irq_o <= |(((evt_status_r & ~evt_clr) | evt_set) & evt_mask_r);
            store_overflow_flag_o <= ovf_r;
            sensor_active_o <= sensor_active_r;
            second_pin_trigger_function_o <= second_pin_trigger_function_r;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // read data and acknowledge
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        if (idx == sbo_pkg::IDX_X_OFFSET) begin
            rd_mux[7:0] = offset_r[0];
        end else if (idx == sbo_pkg::IDX_Y_OFFSET) begin
            rd_mux[7:0] = offset_r[1];
        end else if (idx == sbo_pkg::IDX_Z_OFFSET) begin
            rd_mux[7:0] = offset_r[2];
        end else if (idx == sbo_pkg::IDX_SETUP) begin
            rd_mux[7:0] = setup_r;
        end else if (idx == sbo_pkg::IDX_SETUP_TWO) begin
            rd_mux[5:0] = fill_level_mark_r;
        end else if (idx == sbo_pkg::IDX_SENSOR) begin
            rd_mux[1:0] = {second_pin_trigger_function_r, sensor_active_r};
        end else if (idx == sbo_pkg::IDX_EVT_STATUS) begin
            rd_mux[sbo_pkg::EVT_BITS-1:0] = evt_status_r;
        end else if (idx == sbo_pkg::IDX_EVT_MASK) begin
            rd_mux[sbo_pkg::EVT_BITS-1:0] = evt_mask_r;
        end else if (idx == sbo_pkg::IDX_LEVEL) begin
            rd_mux[11:0] = {gate_r, ovf_r, 2'(trig_r), 2'b00, count_r};
        end else if (idx == sbo_pkg::IDX_DATA_XY && count_r != '0) begin
            rd_mux[2*DW-1:0] = rd_data[2*DW-1:0];
        end else if (idx == sbo_pkg::IDX_DATA_Z && count_r != '0) begin
            rd_mux[DW-1:0] = rd_data[3*DW-1:2*DW];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= take;
            wb_dat_o <= (take && rd_req) ? rd_mux : '0;
        end
    end
endmodule : sbo_ctrl
`default_nettype wire

// File: hw/sbo_pkg.sv
package sbo_pkg;

    // register indices; the byte address is four times the index
    localparam logic [5:0] IDX_X_OFFSET = 6'h22;
    localparam logic [5:0] IDX_Y_OFFSET = 6'h23;
    localparam logic [5:0] IDX_Z_OFFSET = 6'h24;
    localparam logic [5:0] IDX_SETUP = 6'h26;
    localparam logic [5:0] IDX_SETUP_TWO = 6'h27;
    localparam logic [5:0] IDX_SENSOR = 6'h28;
    localparam logic [5:0] IDX_EVT_STATUS = 6'h29;
    localparam logic [5:0] IDX_EVT_MASK = 6'h2A;
    localparam logic [5:0] IDX_LEVEL = 6'h2B;
    localparam logic [5:0] IDX_DATA_XY = 6'h2C;
    localparam logic [5:0] IDX_DATA_Z = 6'h2D;

    // sample_store_setup fields
    localparam int SETUP_ORDER_BIT = 7;
    localparam int SETUP_MODE_LO = 5;
    localparam int SETUP_GATE_BIT = 4;
    localparam int SETUP_WT_BIT = 3;
    localparam int SETUP_OT_BIT = 2;
    localparam int SETUP_OR_BIT = 0;
    localparam logic [7:0] SETUP_MODE_MASK = 8'hE0;

    // sample_store_setup_two and sensor fields
    localparam int TWO_FLUSH_BIT = 7;
    localparam int SENSOR_ACTIVE_BIT = 0;
    localparam int SENSOR_PIN2_BIT = 1;

    // event status bits
    localparam int EVT_OVERFLOW = 0;
    localparam int EVT_MARK = 1;
    localparam int EVT_TRIGGER = 2;
    localparam int EVT_GATE_ERR = 3;
    localparam int EVT_BITS = 4;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [EVT_BITS-1:0] RST_EVT = 4'h0;

    typedef enum logic [1:0] {
        SBO_MODE_OFF = 2'b00,
        SBO_MODE_STREAM = 2'b01,
        SBO_MODE_STOP = 2'b10,
        SBO_MODE_TRIGGER = 2'b11
    } sbo_mode_t;

    typedef enum logic [1:0] {
        SBO_TRIG_ARMED = 2'b00,
        SBO_TRIG_COLLECT = 2'b01,
        SBO_TRIG_HALTED = 2'b10
    } sbo_trig_t;

endpackage : sbo_pkg

// File: hw/sbo_offset_sat.sv
`timescale 1ns/100ps
`default_nettype none
module sbo_offset_sat #(
    parameter int DW = 12
) (
    // raw sample and offset
    input wire logic [DW-1:0] raw_i,
    input wire logic [7:0] offset_i,
    // corrected sample
    output logic [DW-1:0] corr_o
);
    logic [DW+1:0] sum;

    // offset counts two output steps per code
    assign sum = {{2{raw_i[DW-1]}}, raw_i} + {{(DW-7){offset_i[7]}}, offset_i, 1'b0};

    always_comb begin
        if (sum[DW+1:DW-1] == 3'b000 || sum[DW+1:DW-1] == 3'b111) begin
            corr_o = sum[DW-1:0];
        end else if (sum[DW+1]) begin
            corr_o = {1'b1, {(DW-1){1'b0}}};
        end else begin
            corr_o = {1'b0, {(DW-1){1'b1}}};
        end
    end
endmodule : sbo_offset_sat
`default_nettype wire

// File: hw/sbo_sample_mem.sv
`timescale 1ns/100ps
`default_nettype none
module sbo_sample_mem #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    // clock
    input wire logic clk_i,
    // write port
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    // read port
    input wire logic [AW-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    assign rdata_o = mem_r[raddr_i];
endmodule : sbo_sample_mem
`default_nettype wire

// File: tb/sbo_src_model.sv
`timescale 1ns/100ps
`default_nettype none
module sbo_src_model (
    // clock and control
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [5:0] n_i,
    input wire logic [11:0] base_i,
    input wire logic [11:0] z_i,
    // sample lines
    output logic valid_o,
    output logic [11:0] x_o,
    output logic [11:0] y_o,
    output logic [11:0] z_o,
    output logic busy_o
);
    logic [5:0] left_r;
    // one sample every other cycle, lines toggle while idle
    always_ff @(posedge clk_i) begin
        valid_o <= 1'b0;
        x_o <= ~x_o;
        y_o <= ~y_o;
        z_o <= ~z_o;
        if (rst_i) begin
            left_r <= 6'h00;
            {x_o, y_o, z_o} <= 36'h0_0000_0000;
        end else if (go_i) begin
            left_r <= n_i;
        end else if (left_r != 6'h00 && !valid_o) begin
            valid_o <= 1'b1;
            x_o <= base_i + {6'h00, n_i - left_r};
            y_o <= 12'h000;
            z_o <= z_i;
            left_r <= left_r - 6'h01;
        end
    end
    assign busy_o = left_r != 6'h00 || valid_o;
endmodule : sbo_src_model
`default_nettype wire

// File: tb/sbo_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
module sbo_ctrl_sva (
    // bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // status
    input wire logic irq_o,
    input wire logic store_overflow_flag_o,
    input wire logic sensor_active_o,
    input wire logic second_pin_trigger_function_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [5:0] idx;
    logic rd_ack, mapped, is_off;
    logic [7:0] setup_r;
    logic [7:0] off_r [3];
    assign idx = wb_adr_i[7:2];
    assign rd_ack = wb_ack_o && !wb_we_i;
    assign mapped = idx inside {[6'h22:6'h24], [6'h26:6'h2D]};
    assign is_off = idx inside {[6'h22:6'h24]};
    // shadow of the written setup and offset registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            setup_r <= 8'h00;
            off_r <= '{3{8'h00}};
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]) begin
            if (idx == 6'h26) begin
                setup_r[7:5] <= (sensor_active_o || second_pin_trigger_function_o) ?
                    setup_r[7:5] : wb_dat_i[7:5];
                setup_r[4:0] <= wb_dat_i[4:0];
            end
            if (is_off) begin
                off_r[2'(idx - 6'h22)] <= wb_dat_i[7:0];
            end
        end
    end
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd(logic [5:0] i);
        rd_ack && idx == i;
    endsequence
    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_ack_bound;
        s_req |-> ##[1:2] wb_ack_o;
    endproperty
    property p_idle_zero;
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
    endproperty
    property p_unmapped;
        rd_ack && !mapped |-> wb_dat_o == 32'h0000_0000;
    endproperty
    property p_offsets;
        rd_ack && is_off |-> wb_dat_o[7:0] == off_r[2'(idx - 6'h22)];
    endproperty
    property p_setup;
        s_rd(6'h26) |-> wb_dat_o[7:0] == setup_r;
    endproperty
    property p_ovf_copy;
        s_rd(6'h2B) |-> wb_dat_o[10] == store_overflow_flag_o;
    endproperty
    property p_level_max;
        s_rd(6'h2B) |-> wb_dat_o[5:0] <= 6'h20;
    endproperty
    property p_reset;
        $fell(rst_i) |-> !wb_ack_o && !irq_o && !store_overflow_flag_o && !sensor_active_o;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack held");
    a_ack_bound: assert property (p_ack_bound)
        else $error("no ack");
    a_idle_zero: assert property (p_idle_zero)
        else $error("idle data");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_offsets: assert property (p_offsets)
        else $error("offset readback wrong");
    a_setup: assert property (p_setup)
        else $error("setup readback wrong");
    a_ovf_copy: assert property (p_ovf_copy)
        else $error("ovf copy");
    a_level_max: assert property (p_level_max)
        else $error("count above depth");
    a_reset: assert property (p_reset)
        else $error("reset state");
endmodule : sbo_ctrl_sva
bind sbo_ctrl sbo_ctrl_sva i_sbo_ctrl_sva (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .store_overflow_flag_o(store_overflow_flag_o), .sensor_active_o(sensor_active_o),
    .second_pin_trigger_function_o(second_pin_trigger_function_o)
);
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000;
    logic [3:0] evt = 4'h0;
    logic go = 1'b0;
    logic [5:0] n = 6'h00;
    logic [11:0] base = 12'h000;
    logic [11:0] zv = 12'h000;
    logic [31:0] wb_dat_o, q;
    logic wb_ack_o, irq, ovf, act, pin2, sv, busy;
    logic [11:0] sx, sy, sz, f, l;
    logic [2:0] m;
    int failures = 0;
    int comparisons = 0;
    always #12.5 clk_i = ~clk_i;
    sbo_ctrl i_sbo_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .sample_valid_i(sv), .sample_x_i(sx), .sample_y_i(sy),
        .sample_z_i(sz), .within_threshold_evt_i(evt[2]), .outside_threshold_evt_i(evt[1]),
        .orientation_evt_i(evt[0]), .wake_sleep_change_i(evt[3]), .irq_o(irq),
        .store_overflow_flag_o(ovf), .sensor_active_o(act),
        .second_pin_trigger_function_o(pin2)
    );
    sbo_src_model i_sbo_src_model (
        .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .n_i(n), .base_i(base),
        .z_i(zv), .valid_o(sv), .x_o(sx), .y_o(sy), .z_o(sz), .busy_o(busy)
    );
    ////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        dat <= {24'h00_0000, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        q = wb_dat_o;
        cyc <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            failures++;
            results();
        end
    endtask : bus
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        bus(1'b1, i, d);
    endtask : wr
    task automatic rc(input logic [5:0] i, input logic [31:0] e);
        bus(1'b0, i, 8'h00);
        chk(q, e);
    endtask : rc
    task automatic lvl(input logic [31:0] e);
        rc(6'h2B, e);
    endtask : lvl
    task automatic push(input logic [5:0] c, input logic [11:0] b);
        int k;
        @(posedge clk_i);
        go <= 1'b1;
        n <= c;
        base <= b;
        @(posedge clk_i);
        go <= 1'b0;
        k = 0;
        do begin
            @(negedge clk_i);
            k++;
        end while (busy && k < 200);
        if (busy) begin
            failures++;
            results();
        end
    endtask : push
    task automatic ev(input logic [3:0] e);
        @(posedge clk_i);
        evt <= e;
        @(posedge clk_i);
        evt <= 4'h0;
    endtask : ev
    task automatic drain;
        for (int i = 0; i < 32; i++) begin
            bus(1'b0, sbo_pkg::IDX_DATA_XY, 8'h00);
            if (i == 0) f = q[11:0];
            l = q[11:0];
            bus(1'b0, sbo_pkg::IDX_DATA_Z, 8'h00);
        end
    endtask : drain
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wr(6'h25, 8'hFF);
        for (int i = 0; i < 6; i++) rc(6'h22 + 6'(i), 8'h00);
        $display("test reset done");
        wr(6'h22, 8'h10);
        wr(6'h23, 8'h80);
        wr(6'h24, 8'h7F);
        rc(6'h23, 8'h80);
        wr(6'h26, 8'h20);
        zv <= 12'h7F0;
        push(6'h01, 12'h100);
        rc(6'h2C, 24'hF0_0120);
        rc(6'h2D, 12'h7FF);
        for (int i = 0; i < 3; i++) wr(6'h22 + 6'(i), 8'h00);
        $display("test offsets done");
        push(6'h22, 12'h000);
        lvl(12'h420);
        chk(ovf, 1);
        drain();
        chk(f, 2);
        chk(l, 33);
        $display("test stream done");
        wr(6'h26, 8'h40);
        push(6'h22, 12'h100);
        wr(6'h26, 8'hC0);
        lvl(12'h420);
        drain();
        chk(f, 12'h11F);
        chk(l, 12'h100);
        $display("test stop done");
        wr(6'h28, 8'h01);
        wr(6'h26, 8'h20);
        rc(6'h26, 8'hC0);
        chk(act, 1);
        wr(6'h28, 8'h02);
        wr(6'h26, 8'h3F);
        rc(6'h26, 8'hDF);
        chk(pin2, 1);
        wr(6'h28, 8'h00);
        wr(6'h26, 8'h00);
        push(6'h03, 12'h000);
        lvl(12'h000);
        $display("test refusal done");
        wr(6'h27, 8'h04);
        wr(6'h26, 8'h68);
        push(6'h0B, 12'h000);
        lvl(12'h004);
        ev(4'h4);
        push(6'h1E, 12'h020);
        lvl(12'h620);
        chk(ovf, 1);
        drain();
        chk(f, 7);
        chk(l, 12'h03B);
        lvl(12'h000);
        chk(ovf, 0);
        for (int s = 0; s < 3; s++) begin
            m = 3'b100 >> s;
            wr(6'h26, {4'h6, m[2:1], 1'b0, m[0]});
            ev({1'b0, ~m});
            lvl(12'h000);
            ev({1'b0, m});
            lvl(12'h100);
            wr(6'h27, 8'h84);
        end
        $display("test trigger done");
        wr(6'h26, 8'h20);
        push(6'h03, 12'h000);
        lvl(12'h003);
        ev(4'h8);
        lvl(12'h000);
        chk(irq, 0);
        wr(6'h2A, 8'h01);
        @(negedge clk_i);
        chk(irq, 1);
        wr(6'h29, 8'h01);
        @(negedge clk_i);
        chk(irq, 0);
        $display("test flush and irq done");
        results();
    end
endmodule : tb
`default_nettype wire
